// >>> hw/bsf_pkg.sv
// package: states, register map, timing constants and carrier types of the sequencer
package bsf_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int NCH    = 6;
    // times in ms as printed, cycle counts derived from the clock rate
    localparam int SOFTSTART_MS  = 25;
    localparam int BOOSTRAMP_MS  = 50;
    localparam int RECOVERY_MS   = 100;
    localparam int DISCHARGE_MS  = 400;
    localparam int BUS_TIMEOUT_MS = 500;
    localparam int INT_SHORT_MS  = 5;
    localparam int SOFTSTART_CYC = SOFTSTART_MS * (CLK_HZ / 1000);
    localparam int BOOSTRAMP_CYC = BOOSTRAMP_MS * (CLK_HZ / 1000);
    localparam int RECOVERY_CYC  = RECOVERY_MS * (CLK_HZ / 1000);
    localparam int DISCHARGE_CYC = DISCHARGE_MS * (CLK_HZ / 1000);
    localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int INT_SHORT_CYC = INT_SHORT_MS * (CLK_HZ / 1000);
    localparam int INIT_CYC      = 16;
    // current code forced when the resistor pin is shorted (limits total to 70mA)
    localparam logic [11:0] CURRENT_SET_RESISTOR_PIN_FORCE_CODE = 12'h3ff;
    localparam logic [11:0] CURRENT_RST     = 12'hfff;
    // word offsets on the bus
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_INTEN  = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_STATE  = 4'h3;
    localparam logic [3:0] OFS_STRING = 4'h4;
    // fault flag bit positions
    localparam int F_CURRENT_SET_RESISTOR_PIN = 0;
    localparam int F_TSD  = 1;
    localparam int F_OPEN = 2;
    localparam int F_ISHT = 3;
    localparam int F_GND  = 4;
    localparam int F_INV  = 5;
    localparam int F_BUS  = 6;
    localparam int NFLT   = 7;
    localparam logic [1:0] IEN_OFF = 2'h1;
    localparam logic [1:0] IEN_ON  = 2'h3;
    localparam logic [1:0] IEN_RD_ON = 2'h2;
    localparam logic [13:0] INTEN_RST = 14'h2aaa;
    localparam logic [31:0] CNT_ZERO = 32'h0;

    typedef enum logic [2:0] {
        BSF_INIT, BSF_STANDBY, BSF_SOFTSTART, BSF_BOOSTRAMP,
        BSF_NORMAL, BSF_RECOVERY, BSF_LATCH, BSF_SHUTDOWN
    } bsf_state_t;

    // analog condition inputs, per channel where it applies
    typedef struct packed {
        logic [NCH-1:0] headroom_low;
        logic [NCH-1:0] above_short_level;
        logic [NCH-1:0] below_gnd_level;
        logic [NCH-1:0] unused_not_grounded;
        logic           boost_at_max;
        logic           over_temp;
        logic           current_set_resistor_pin_low;
    } bsf_sense_t;

    // power stage controls
    typedef struct packed {
        logic           switch_on;
        logic           boost_on;
        logic           boost_reduced_limit;
        logic           discharge;
        logic           test_current;
        logic [NCH-1:0] driver_en;
    } bsf_drive_t;
endpackage : bsf_pkg

// >>> hw/bsf_sequencer.sv
// file: functional state machine and fault supervisor of the backlight driver
// Contract
// RL1 - resistor short: flag, interrupt, force current 0x3ff
// RL2 - over temperature: flag, recover, wait cool
// RL3 - open string: flag, disable string till repower
// RL4 - internal short over 5ms: flag, disable string
// RL5 - soft start: headroom low with test current
// RL6 - ramp/normal: below ground level while off
// RL7 - ground short: flag, recover, retry 100ms
// RL8 - unused output not grounded: flag, continue
// RL9 - bus without stop 500ms: flag, continue
// RL10 - enable low: all off, discharge 400ms
// RL11 - after reset: init, load settings, detect
// RL12 - configuration writes accepted from standby on
// RL13 - standby goes straight to soft start
// RL14 - soft start lasts 25ms, supply faults on
// RL15 - boost ramp 50ms, reduced limit, faults
// RL16 - normal: drivers on while brightness nonzero
// RL17 - recovery 100ms off, restart if enabled
// RL18 - all strings disabled: latch until enable low
// RL19 - clear needs status and clear bits together
// RL20 - enable field: 01 off, 11 on, reads 10
// RL21 - flags sticky, interrupt while enabled set
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module bsf_sequencer
    import bsf_pkg::*;
#(
    parameter int SOFTSTART_N = SOFTSTART_CYC,
    parameter int BOOSTRAMP_N = BOOSTRAMP_CYC,
    parameter int RECOVERY_N  = RECOVERY_CYC,
    parameter int DISCHARGE_N = DISCHARGE_CYC,
    parameter int BUSTMO_N    = BUS_TIMEOUT_CYC,
    parameter int ISHORT_N    = INT_SHORT_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        enable_pin_i,
    input  wire logic [15:0] brightness_i,
    input  wire bsf_sense_t  sense_i,
    input  wire logic        bus_cmd_open_i,
    input  wire logic        nvm_loaded_i,
    input  wire logic [NCH-1:0] used_mask_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output bsf_drive_t       drive_o,
    output logic [11:0]      string_current_code_o,
    output logic             fault_int_o,
    output logic             regulator_on_o,
    output logic             powered_down_o
);
    // the enable pin passes a three-stage chain, a change counts when stages 2 and 3 agree
    logic [2:0] en_sync_q;
    logic       en_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_sync_q <= 3'h0;
            en_q      <= 1'b0;
        end else begin
            en_sync_q <= {en_sync_q[1:0], enable_pin_i};
            if (en_sync_q[2] == en_sync_q[1]) begin
                en_q <= en_sync_q[2];
            end
        end
    end

    bsf_state_t     st_q, st_d;
    logic [31:0]    cnt_q, cnt_d;
    logic [NFLT-1:0] flag_q, flag_d;
    logic [13:0]    inten_q, inten_d;
    logic [NCH-1:0] dead_q, dead_d;
    logic [11:0]    cur_q, cur_d;
    logic [31:0]    ish_q, ish_d;
    logic [31:0]    bus_q, bus_d;
    logic           int_q, int_d;
    logic [31:0]    rdat_q, rdat_d;
    logic           ack_q, ack_d;
    bsf_drive_t     drv_q, drv_d;
    logic           reg_on_q, reg_on_d;
    logic           off_q, off_d;

    // two-bit enable field: 10 reads as armed
    function automatic logic armed(input logic [13:0] f, input int i);
        armed = (f[2*i+:2] == IEN_RD_ON);
    endfunction : armed

    logic [NCH-1:0] live;
    logic [NCH-1:0] open_det, gnd_det, ishort_now;
    logic           ishort_fire, bright_nz, wr, cfg_ok;
    always_comb begin
        live        = used_mask_i & ~dead_q;
        bright_nz   = (brightness_i != 16'h0);
        open_det    = (st_q == BSF_NORMAL && sense_i.boost_at_max) ?
                      (live & sense_i.headroom_low) : '0; // see RL3
        ishort_now  = live & sense_i.above_short_level;
        ishort_fire = (st_q == BSF_NORMAL) && (ishort_now != '0) &&
                      ((live & ~sense_i.above_short_level) != '0) &&
                      (ish_q >= 32'(ISHORT_N)); // see RL4
        gnd_det     = '0;
        if (st_q == BSF_SOFTSTART) begin
            gnd_det = live & sense_i.headroom_low; // see RL5
        end else if (st_q == BSF_BOOSTRAMP || st_q == BSF_NORMAL) begin
            gnd_det = live & sense_i.below_gnd_level & ~drv_q.driver_en; // see RL6
        end
        wr     = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
        cfg_ok = (st_q != BSF_INIT) && (st_q != BSF_SHUTDOWN); // see RL12
    end

    // sequencer next state, counters and power stage controls
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q + 32'h1;
        dead_d   = dead_q;
        reg_on_d = reg_on_q;
        off_d    = off_q;
        drv_d    = '0;
        unique case (st_q)
            BSF_INIT: begin
                reg_on_d = 1'b1; // see RL11
                if (nvm_loaded_i && cnt_q >= 32'(INIT_CYC)) begin
                    st_d  = BSF_STANDBY;
                    cnt_d = CNT_ZERO;
                end
            end
            BSF_STANDBY: begin
                if (!sense_i.over_temp && !sense_i.current_set_resistor_pin_low) begin
                    st_d  = BSF_SOFTSTART; // see RL13
                    cnt_d = CNT_ZERO;
                end
            end
            BSF_SOFTSTART: begin
                drv_d.switch_on    = 1'b1; // see RL14
                drv_d.test_current = 1'b1;
                if (cnt_q >= 32'(SOFTSTART_N) - 32'h1) begin
                    st_d  = BSF_BOOSTRAMP;
                    cnt_d = CNT_ZERO;
                end
            end
            BSF_BOOSTRAMP: begin
                drv_d.switch_on           = 1'b1;
                drv_d.boost_on            = 1'b1;
                drv_d.boost_reduced_limit = 1'b1; // see RL15
                drv_d.test_current        = 1'b1;
                if (cnt_q >= 32'(BOOSTRAMP_N) - 32'h1) begin
                    st_d  = BSF_NORMAL;
                    cnt_d = CNT_ZERO;
                end
            end
            BSF_NORMAL: begin
                drv_d.switch_on    = 1'b1;
                drv_d.boost_on     = 1'b1;
                drv_d.test_current = 1'b1;
                drv_d.driver_en    = bright_nz ? live : '0; // see RL16
            end
            BSF_RECOVERY: begin
                // everything off; over temperature holds the retry back
                if (cnt_q >= 32'(RECOVERY_N) - 32'h1 && en_q && bright_nz &&
                    !sense_i.over_temp) begin
                    st_d  = BSF_STANDBY; // see RL17 RL2 RL7
                    cnt_d = CNT_ZERO;
                end
            end
            BSF_LATCH: begin
                cnt_d = CNT_ZERO; // see RL18
            end
            BSF_SHUTDOWN: begin
                drv_d.discharge = (cnt_q < 32'(DISCHARGE_N)); // see RL10
                if (cnt_q >= 32'(DISCHARGE_N)) begin
                    cnt_d    = cnt_q;
                    off_d    = 1'b1;
                    reg_on_d = 1'b0;
                end
            end
        endcase
        // string disables and fault reactions in active states
        if (st_q == BSF_NORMAL) begin
            dead_d = dead_q | open_det | (ishort_fire ? ishort_now : '0); // see RL3 RL4
        end
        if (st_q inside {BSF_SOFTSTART, BSF_BOOSTRAMP, BSF_NORMAL}) begin
            if (sense_i.over_temp || gnd_det != '0) begin
                st_d  = BSF_RECOVERY; // see RL2 RL7
                cnt_d = CNT_ZERO;
            end else if (used_mask_i != '0 && (used_mask_i & ~dead_d) == '0) begin
                st_d  = BSF_LATCH; // see RL18
                cnt_d = CNT_ZERO;
            end
        end
        if (!en_q && st_q != BSF_INIT && st_q != BSF_SHUTDOWN) begin
            st_d  = BSF_SHUTDOWN; // see RL10
            cnt_d = CNT_ZERO;
        end
        if (en_q && st_q == BSF_SHUTDOWN && off_q) begin
            st_d     = BSF_INIT; // power cycle re-enables strings
            cnt_d    = CNT_ZERO;
            dead_d   = '0;
            off_d    = 1'b0;
        end
    end

    // fault flags, bus timers, current code and register bus
    always_comb begin
        flag_d  = flag_q;
        inten_d = inten_q;
        cur_d   = cur_q;
        ish_d   = ((st_q == BSF_NORMAL) && ishort_now != '0) ? ish_q + 32'h1 : CNT_ZERO;
        bus_d   = bus_cmd_open_i ? bus_q + 32'h1 : CNT_ZERO;
        ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
        rdat_d  = 32'h0;
        // clear only when status and its clear bit are both one; a set still wins
        if (wr && wb_adr_i[5:2] == OFS_STATUS && wb_sel_i[0]) begin
            flag_d = flag_q & ~(wb_dat_i[NFLT-1:0] & wb_dat_i[NFLT+7:8]); // see RL19
        end
        if (wr && cfg_ok && wb_adr_i[5:2] == OFS_INTEN) begin
            for (int i = 0; i < NFLT; i++) begin
                if (wb_dat_i[2*i+:2] == IEN_OFF) inten_d[2*i+:2] = 2'h0; // see RL20
                if (wb_dat_i[2*i+:2] == IEN_ON)  inten_d[2*i+:2] = IEN_RD_ON;
            end
        end
        if (wr && cfg_ok && wb_adr_i[5:2] == OFS_CONFIG && !sense_i.current_set_resistor_pin_low) begin
            cur_d = wb_dat_i[11:0]; // see RL12
        end
        if (sense_i.current_set_resistor_pin_low) begin
            flag_d[F_CURRENT_SET_RESISTOR_PIN] = 1'b1;
            cur_d          = CURRENT_SET_RESISTOR_PIN_FORCE_CODE; // see RL1
        end
        if (sense_i.over_temp) flag_d[F_TSD] = 1'b1; // see RL2
        if (open_det != '0)    flag_d[F_OPEN] = 1'b1; // see RL3
        if (ishort_fire)       flag_d[F_ISHT] = 1'b1; // see RL4
        if (gnd_det != '0)     flag_d[F_GND] = 1'b1; // see RL7
        if (st_q != BSF_INIT && (sense_i.unused_not_grounded & ~used_mask_i) != '0) begin
            flag_d[F_INV] = 1'b1; // see RL8
        end
        if (bus_q == 32'(BUSTMO_N)) flag_d[F_BUS] = 1'b1; // see RL9
        int_d = 1'b0;
        for (int i = 0; i < NFLT; i++) begin
            if (flag_q[i] && armed(inten_q, i)) int_d = 1'b1; // see RL21
        end
        unique case (wb_adr_i[5:2])
            OFS_CONFIG: rdat_d = {20'h0, cur_q};
            OFS_INTEN:  rdat_d = {18'h0, inten_q};
            OFS_STATUS: rdat_d = {25'h0, flag_q};
            OFS_STATE:  rdat_d = {29'h0, st_q};
            OFS_STRING: rdat_d = {26'h0, dead_q};
            default:    rdat_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q     <= BSF_INIT;
            cnt_q    <= CNT_ZERO;
            flag_q   <= '0;
            inten_q  <= INTEN_RST;
            dead_q   <= '0;
            cur_q    <= CURRENT_RST;
            ish_q    <= CNT_ZERO;
            bus_q    <= CNT_ZERO;
            int_q    <= 1'b0;
            rdat_q   <= 32'h0;
            ack_q    <= 1'b0;
            drv_q    <= '0;
            reg_on_q <= 1'b0;
            off_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            flag_q   <= flag_d;
            inten_q  <= inten_d;
            dead_q   <= dead_d;
            cur_q    <= cur_d;
            ish_q    <= ish_d;
            bus_q    <= bus_d;
            int_q    <= int_d;
            rdat_q   <= rdat_d;
            ack_q    <= ack_d;
            drv_q    <= drv_d;
            reg_on_q <= reg_on_d;
            off_q    <= off_d;
        end
    end

    always_comb begin
        wb_dat_o              = rdat_q;
        wb_ack_o              = ack_q;
        drive_o               = drv_q;
        string_current_code_o = cur_q;
        fault_int_o           = int_q;
        regulator_on_o        = reg_on_q;
        powered_down_o        = off_q;
    end

    // checks
    AST_CURRENT_SET_RESISTOR_PIN_FORCE: assert property (@(posedge clk_i) disable iff (rst_i) // see RL1
        sense_i.current_set_resistor_pin_low |=> (cur_q == CURRENT_SET_RESISTOR_PIN_FORCE_CODE) && flag_q[F_CURRENT_SET_RESISTOR_PIN])
        else $error("current code not forced on resistor short");
    AST_GND_RECOVER: assert property (@(posedge clk_i) disable iff (rst_i) // see RL7
        (gnd_det != '0 && en_q) |=> st_q == BSF_RECOVERY && flag_q[F_GND])
        else $error("ground short did not enter recovery");
    AST_REC_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // see RL17
        (st_q == BSF_RECOVERY) |=> (drv_q == '0))
        else $error("power stage on during recovery");
    AST_SHUT: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
        (st_q != BSF_SHUTDOWN && st_q != BSF_INIT && !en_q) |=> st_q == BSF_SHUTDOWN)
        else $error("enable low did not shut down");
    AST_STANDBY_GO: assert property (@(posedge clk_i) disable iff (rst_i) // see RL13
        (st_q == BSF_STANDBY && en_q && !sense_i.over_temp && !sense_i.current_set_resistor_pin_low)
        |=> st_q == BSF_SOFTSTART)
        else $error("standby did not advance");
    AST_NORMAL_DARK: assert property (@(posedge clk_i) disable iff (rst_i) // see RL16
        (st_q == BSF_NORMAL && brightness_i == 16'h0) |=> drv_q.driver_en == '0)
        else $error("drivers on with zero brightness");
    AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL18
        (st_q == BSF_LATCH && en_q) |=> st_q == BSF_LATCH)
        else $error("latch left while enabled");
    AST_INT: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
        (flag_q[F_TSD] && armed(inten_q, F_TSD)) |=> fault_int_o)
        else $error("interrupt missing for armed flag");
    AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
        (flag_q[F_BUS] && !wr) |=> flag_q[F_BUS])
        else $error("flag dropped without clear");
    AST_SS_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5 RL14
        (st_q == BSF_SOFTSTART) |=> drv_q.switch_on && drv_q.test_current && !drv_q.boost_on)
        else $error("soft start drive wrong");
    AST_RAMP_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i) // see RL15
        (st_q == BSF_BOOSTRAMP) |=> drv_q.boost_on && drv_q.boost_reduced_limit)
        else $error("boost ramp without reduced limit");
    AST_OPEN_DROP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL3
        (open_det != '0) |=> flag_q[F_OPEN] && ((dead_q & $past(open_det)) == $past(open_det)))
        else $error("open string not flagged and dropped");
    AST_ISHORT_DROP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
        ishort_fire |=> flag_q[F_ISHT] && ((dead_q & $past(ishort_now)) == $past(ishort_now)))
        else $error("internal short not flagged and dropped");
    AST_BUS_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // see RL9
        (bus_q == 32'(BUSTMO_N)) |=> flag_q[F_BUS])
        else $error("bus timeout not flagged");
    AST_SHUT_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
        (st_q == BSF_SHUTDOWN) |=> !drv_q.switch_on && !drv_q.boost_on && drv_q.driver_en == '0)
        else $error("power stage on in shutdown");
endmodule : bsf_sequencer

// >>> tb/bsf_host_model.sv
// host model: enable pin, brightness, serial command state and bus master
`timescale 1ns/1ps
module bsf_host_model
    import bsf_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_i,
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [5:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o,
    output logic             enable_o,
    output logic [15:0]      brightness_o,
    output logic             cmd_open_o
);
    // idle bus and pins at time zero
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
        wb_adr_o     = 6'h3f;
        wb_sel_o     = 4'h0;
        wb_dat_o     = 32'h5a5a5a5a;
        enable_o     = 1'b0;
        brightness_o = 16'h0;
        cmd_open_o   = 1'b0;
    end

    // one classic cycle; held until ack is sampled, data taken at that edge
    task xfer(input logic w, input logic [5:0] a, input logic [3:0] s, input logic [31:0] d,
              output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= s;
        wb_dat_o <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 64);
        ok = (wb_ack_i === 1'b1);
        q  = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_dat_o <= ~d; // released data must not look like the last word
    endtask : xfer

    // pins change just after an edge
    task set_en(input logic v);
        @(posedge clk_i);
        enable_o <= v;
    endtask : set_en

    task set_brt(input logic [15:0] v);
        @(posedge clk_i);
        brightness_o <= v;
    endtask : set_brt

    task set_open(input logic v);
        @(posedge clk_i);
        cmd_open_o <= v;
    endtask : set_open
endmodule : bsf_host_model

// >>> tb/bsf_sequencer_tb_top.sv
// testbench: sequencer against a reference of flags, states and registers
`timescale 1ns/1ps
module bsf_sequencer_tb_top
    import bsf_pkg::*;
;
    localparam int SS = 40, BR = 40, RC = 50, DC = 50, BT = 50, IS = 30;
    localparam logic [5:0] A_CFG = {OFS_CONFIG, 2'b00}, A_IEN = {OFS_INTEN, 2'b00};
    localparam logic [5:0] A_ST = {OFS_STATUS, 2'b00}, A_FSM = {OFS_STATE, 2'b00};
    localparam logic [5:0] A_STR = {OFS_STRING, 2'b00};
    logic clk_i = 1'b0, rst_i = 1'b1, nvm = 1'b0, en, opn, cyc, stb, we, ack, intr, pdn, regon;
    logic [15:0] brt;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, d, q;
    logic [11:0] code;
    logic        ok;
    logic [5:0]  used = 6'h0f;
    bsf_sense_t  sns = '0;
    bsf_drive_t  drv;
    int err_count = 0, cmp_count = 0, seed = 32'h1ac67bee, flags = 0;

    always #50 clk_i = ~clk_i;

    bsf_host_model i_bsf_host_model (.clk_i(clk_i), .wb_dat_i(rdat), .wb_ack_i(ack),
        .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(wdat), .enable_o(en), .brightness_o(brt), .cmd_open_o(opn));

    bsf_sequencer #(.SOFTSTART_N(SS), .BOOSTRAMP_N(BR), .RECOVERY_N(RC),
        .DISCHARGE_N(DC), .BUSTMO_N(BT), .ISHORT_N(IS)) i_bsf_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .enable_pin_i(en), .brightness_i(brt),
        .sense_i(sns), .bus_cmd_open_i(opn), .nvm_loaded_i(nvm), .used_mask_i(used),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .drive_o(drv),
        .string_current_code_o(code), .fault_int_o(intr), .regulator_on_o(regon),
        .powered_down_o(pdn));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // register read compared with the reference
    task rd_chk(input logic [5:0] a, input logic [31:0] exp);
        i_bsf_host_model.xfer(1'b0, a, 4'($random(seed)), 32'h0, q, ok);
        if (!ok) err_count++;
        chk(q, exp);
    endtask : rd_chk

    task wr(input logic [5:0] a, input logic [31:0] v);
        i_bsf_host_model.xfer(1'b1, a, 4'hf, v, q, ok);
        if (!ok) err_count++;
    endtask : wr

    // poll the state register under a bound
    task wait_state(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            i_bsf_host_model.xfer(1'b0, A_FSM, 4'($random(seed)), 32'h0, q, ok);
            n++;
        end while (q[2:0] !== s && n < 400);
        chk(32'(q[2:0]), 32'(s));
    endtask : wait_state

    task tally_and_finish;
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // watchdog sized well beyond the expected run of about a thousand cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        i_bsf_host_model.set_en(1'b1);
        i_bsf_host_model.set_brt(16'($random(seed)) | 16'h1);
        rd_chk(A_FSM, 32'h0);
        rd_chk(A_IEN, 32'h2aaa);
        chk(32'(code), 32'hfff);
        wr(A_CFG, 32'h055);
        repeat (30) @(posedge clk_i);
        rd_chk(A_FSM, 32'h0);
        chk(32'(regon), 32'h1);
        nvm <= 1'b1;
        wait_state(BSF_SOFTSTART);
        chk(32'({drv.switch_on, drv.boost_on, drv.test_current}), 32'h5);
        repeat (SS - 14) @(posedge clk_i);
        rd_chk(A_FSM, 32'h2);
        wait_state(BSF_BOOSTRAMP);
        chk(32'(drv.boost_reduced_limit), 32'h1);
        repeat (BR - 14) @(posedge clk_i);
        rd_chk(A_FSM, 32'h3);
        wait_state(BSF_NORMAL);
        chk(32'(drv.driver_en), 32'(used));
        rd_chk(A_CFG, 32'hfff);
        i_bsf_host_model.set_brt(16'h0);
        repeat (4) @(posedge clk_i);
        chk(32'(drv.driver_en), 32'h0);
        i_bsf_host_model.set_brt(16'($random(seed)) | 16'h1);
        d = 32'($random(seed)) & 32'hfff;
        wr(A_CFG, d);
        rd_chk(A_CFG, d);
        chk(32'(code), d);
        // serial command left open: flag, interrupt, masking and clearing
        i_bsf_host_model.set_open(1'b1);
        repeat (BT + 5) @(posedge clk_i);
        i_bsf_host_model.set_open(1'b0);
        flags |= 32'h40;
        rd_chk(A_ST, flags);
        rd_chk(A_FSM, 32'h4);
        chk(32'(intr), 32'h1);
        wr(A_ST, 32'h40);
        rd_chk(A_ST, flags);
        wr(A_IEN, 32'h1000);
        rd_chk(A_IEN, 32'h0aaa);
        repeat (2) @(posedge clk_i);
        chk(32'(intr), 32'h0);
        wr(A_IEN, 32'h3000);
        rd_chk(A_IEN, 32'h2aaa);
        chk(32'(intr), 32'h1);
        i_bsf_host_model.xfer(1'b1, A_ST, 4'he, 32'h4040, q, ok);
        rd_chk(A_ST, flags);
        wr(A_ST, 32'h4040);
        flags = 0;
        rd_chk(A_ST, flags);
        repeat (2) @(posedge clk_i);
        chk(32'(intr), 32'h0);
        // resistor short: no recovery, current code forced
        sns.current_set_resistor_pin_low <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(32'(code), 32'(CURRENT_SET_RESISTOR_PIN_FORCE_CODE));
        rd_chk(A_FSM, 32'h4);
        sns.current_set_resistor_pin_low <= 1'b0;
        flags |= 32'h1;
        rd_chk(A_ST, flags);
        // unused output found live
        sns.unused_not_grounded <= 6'h30;
        repeat (3) @(posedge clk_i);
        sns.unused_not_grounded <= 6'h0;
        flags |= 32'h20;
        rd_chk(A_ST, flags);
        rd_chk(A_FSM, 32'h4);
        wr(A_ST, 32'h7f7f);
        flags = 0;
        // over temperature holds recovery until cool
        sns.over_temp <= 1'b1;
        wait_state(BSF_RECOVERY);
        chk(32'({drv.switch_on, drv.boost_on, drv.driver_en}), 32'h0);
        repeat (RC + 20) @(posedge clk_i);
        rd_chk(A_FSM, 32'h5);
        sns.over_temp <= 1'b0;
        flags |= 32'h2;
        rd_chk(A_ST, flags);
        wait_state(BSF_NORMAL);
        // ground short with drivers off, then in soft start
        i_bsf_host_model.set_brt(16'h0);
        sns.below_gnd_level <= 6'h01;
        wait_state(BSF_RECOVERY);
        sns.below_gnd_level <= 6'h0;
        repeat (RC - 14) @(posedge clk_i);
        rd_chk(A_FSM, 32'h5);
        repeat (30) @(posedge clk_i);
        rd_chk(A_FSM, 32'h5);
        i_bsf_host_model.set_brt(16'($random(seed)) | 16'h1);
        wait_state(BSF_SOFTSTART);
        sns.headroom_low <= 6'h0f;
        wait_state(BSF_RECOVERY);
        sns.headroom_low <= 6'h0;
        flags |= 32'h10;
        rd_chk(A_ST, flags);
        wr(A_ST, 32'h7f7f);
        flags = 0;
        wait_state(BSF_NORMAL);
        // internal short, open string, then every string lost
        sns.above_short_level <= 6'h01;
        repeat (IS + 10) @(posedge clk_i);
        sns.above_short_level <= 6'h0;
        rd_chk(A_STR, 32'h1);
        chk(32'(drv.driver_en), 32'h0e);
        sns.boost_at_max <= 1'b1;
        sns.headroom_low <= 6'h02;
        repeat (5) @(posedge clk_i);
        sns.headroom_low <= 6'h0;
        flags |= 32'hc;
        rd_chk(A_STR, 32'h3);
        rd_chk(A_ST, flags);
        sns.headroom_low <= 6'h0c;
        wait_state(BSF_LATCH);
        sns.headroom_low <= 6'h0;
        sns.boost_at_max <= 1'b0;
        repeat (50) @(posedge clk_i);
        rd_chk(A_FSM, 32'h6);
        // enable low: all off, discharge, power down, then restart clean
        i_bsf_host_model.set_en(1'b0);
        wait_state(BSF_SHUTDOWN);
        chk(32'({drv.switch_on, drv.boost_on, drv.driver_en}), 32'h0);
        chk(32'(drv.discharge), 32'h1);
        repeat (DC - 16) @(posedge clk_i);
        chk(32'(pdn), 32'h0);
        repeat (25) @(posedge clk_i);
        chk(32'(pdn), 32'h1);
        chk(32'({drv.discharge, regon}), 32'h0);
        nvm <= 1'b0;
        i_bsf_host_model.set_en(1'b1);
        repeat (30) @(posedge clk_i);
        rd_chk(A_FSM, 32'h0);
        nvm <= 1'b1;
        wait_state(BSF_NORMAL);
        rd_chk(A_STR, 32'h0);
        used <= 6'($random(seed)) | 6'h01;
        repeat (3) @(posedge clk_i);
        chk(32'(drv.driver_en), 32'(used));
        rd_chk(6'h3c, 32'h0);
        tally_and_finish();
    end
endmodule : bsf_sequencer_tb_top
